// *** logic/rwdt_pkg.sv ***
package rwdt_pkg;

  // Control register field positions
  localparam int unsigned CTL_RUN_BIT     = 0;
  localparam int unsigned CTL_RUNAWAY_BIT = 1;
  localparam int unsigned CTL_USER_BIT    = 2;
  localparam int unsigned CTL_HOLD_BIT    = 3;
  localparam int unsigned CTL_WRST_BIT    = 4;
  localparam int unsigned CTL_MODE_BIT    = 5;

  localparam logic [7:0]  CTL_RESET_VAL   = 8'h00;
  localparam logic [7:0]  CTL_WRITE_MASK  = 8'h3F;
  localparam logic [7:0]  CTL_KEEP_ON_WRST = 8'h3C;

  // Base timer prescale step before the watchdog counter
  localparam logic [12:0] PRE_FAST_LAST   = 13'h001F;
  localparam logic [12:0] PRE_SLOW_LAST   = 13'h1FFF;
  localparam int unsigned PRE_W           = 13;
  localparam int unsigned WCNT_W          = 3;
  localparam logic [2:0]  WCNT_ZERO       = 3'h0;
  localparam logic [2:0]  WCNT_LAST       = 3'h7;
  localparam logic [1:0]  CNT_FAST_A      = 2'h0;
  localparam logic [1:0]  CNT_FAST_B      = 2'h1;

  localparam logic [23:0] RUNAWAY_VECTOR  = 24'h00_8000;

  typedef enum logic [1:0] {
    RWDT_IDLE  = 2'b00,
    RWDT_RUN   = 2'b01,
    RWDT_RESET = 2'b10
  } rwdt_state_t;

endpackage

// *** logic/rwdt_tick_gen.sv ***
`timescale 1ns/1ps
// Divides the selected base timer input clock into base timer output ticks
module rwdt_tick_gen
  import rwdt_pkg::*;
(
  input  wire logic CLK_I,
  input  wire logic RST_B_I,
  input  wire logic clk_en_i,
  input  wire logic clear_i,
  input  wire logic fast_i,
  output logic      tick_o
);

  logic [12:0] pre_q;
  logic [12:0] pre_d;
  logic        tick_q;
  logic        tick_d;
  logic [12:0] last;

  always_comb begin
    last   = fast_i ? PRE_FAST_LAST : PRE_SLOW_LAST; // [R9] [R10]
    pre_d  = pre_q;
    tick_d = 1'b0;
    if (clear_i) begin
      pre_d = '0;
    end else if (clk_en_i) begin
      if (pre_q >= last) begin
        pre_d  = '0;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // rwdt_tick_gen

// *** logic/rwdt_top.sv ***
`timescale 1ns/1ps
//
// Contract
// [R1] Starting the watchdog with the base timer stopped or its oscillator off forces a reset.
// [R2] Software sets run, reset-mode select and hold-suspend together in one write to start.
// [R3] Once running, writes to the control register are ignored except the counter clear.
// [R4] Writing zero to the run bit does not stop a running watchdog.
// [R5] The running counter counts up and its overflow raises a reset or an interrupt per mode.
// [R6] Only a single-bit clear aimed at bit 0 of the control register clears the counter.
// [R7] Counter overflow sets the runaway flag; the code sets it in interrupt mode only, and reset mode clears it.
// [R8] Reset mode resets the device; interrupt mode interrupts and resumes at address 8000H.
// [R9] Fast bit one with count field 00 or 01 gives a period of 32 times 8 input clocks.
// [R10] Any other fast bit and count field setting gives a period of 8192 times 8 input clocks.
// [R11] The input clock is the source picked by the base timer clock select register.
// [R12] Software clears the counter more often than the watchdog period.
// [R13] The counter is a 3-bit up-counter stepped once per base timer output pulse.
// [R14] A watchdog reset sets the reset flag and the reset sequence leaves it set.
// [R15] With hold-suspend set, entering hold clears the run bit; otherwise run is unchanged.
// [R16] Interrupt mode keeps the control state except for setting the runaway flag.
// [R17] The counter stays at zero while the watchdog is stopped.
module rwdt_top
  import rwdt_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CTL_WR_I,
  input  wire logic [7:0]  CTL_WDATA_I,
  input  wire logic        CTL_BITCLR_I,
  input  wire logic [2:0]  CTL_BITCLR_IDX_I,
  input  wire logic        BT_RUN_I,
  input  wire logic        BT_OSC_EN_I,
  input  wire logic        BT_CLK_EN_I,
  input  wire logic        BT_FAST_I,
  input  wire logic [1:0]  BT_COUNT_I,
  input  wire logic        HOLD_ENTER_I,
  input  wire logic        RESET_INSTR_I,
  output logic [7:0]       CTL_RDATA_O,
  output logic [2:0]       WDT_COUNT_O,
  output logic             WDT_RESET_REQ_O,
  output logic             WDT_IRQ_O,
  output logic [23:0]      WDT_VECTOR_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic       bt_run_m_q;
  logic       bt_run_s_q;
  logic       bt_osc_m_q;
  logic       bt_osc_s_q;
  logic       bt_clk_m_q;
  logic       bt_clk_s_q;
  logic       bt_clk_p_q;
  logic       bt_clk_rise;

  // Selected base timer input clock arrives as a level; one tick per rising edge
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      bt_run_m_q <= 1'b0;
      bt_run_s_q <= 1'b0;
      bt_osc_m_q <= 1'b0;
      bt_osc_s_q <= 1'b0;
      bt_clk_m_q <= 1'b0;
      bt_clk_s_q <= 1'b0;
      bt_clk_p_q <= 1'b0;
    end else begin
      bt_run_m_q <= BT_RUN_I;
      bt_run_s_q <= bt_run_m_q;
      bt_osc_m_q <= BT_OSC_EN_I;
      bt_osc_s_q <= bt_osc_m_q;
      bt_clk_m_q <= BT_CLK_EN_I;
      bt_clk_s_q <= bt_clk_m_q;
      bt_clk_p_q <= bt_clk_s_q;
    end
  end

  assign bt_clk_rise = bt_clk_s_q & ~bt_clk_p_q; // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Base timer output ticks

  logic fast_sel;
  logic bt_tick;
  logic run_q;

  assign fast_sel = BT_FAST_I & ((BT_COUNT_I == CNT_FAST_A) | (BT_COUNT_I == CNT_FAST_B)); // [R9]

  rwdt_tick_gen u_tick (
    .CLK_I    (CLK_I),
    .RST_B_I  (RST_B_I),
    .clk_en_i (bt_clk_rise),
    .clear_i  (~run_q),
    .fast_i   (fast_sel),
    .tick_o   (bt_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register, counter and outcome

  rwdt_state_t state_q;
  rwdt_state_t state_d;
  logic [7:0]  ctl_q;
  logic [7:0]  ctl_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic        rst_req_q;
  logic        rst_req_d;
  logic        irq_q;
  logic        irq_d;
  logic        clr_hit;
  logic        overflow;
  logic        start_wr;

  assign run_q    = ctl_q[CTL_RUN_BIT];
  assign clr_hit  = CTL_BITCLR_I & (CTL_BITCLR_IDX_I == 3'(CTL_RUN_BIT)); // [R6]
  assign overflow = run_q & bt_tick & (cnt_q == WCNT_LAST);
  assign start_wr = CTL_WR_I & CTL_WDATA_I[CTL_RUN_BIT] & ~run_q; // [R2]

  always_comb begin
    state_d   = state_q;
    ctl_d     = ctl_q;
    cnt_d     = cnt_q;
    rst_req_d = 1'b0;
    irq_d     = 1'b0;
    unique case (state_q)
      RWDT_IDLE: begin
        cnt_d = WCNT_ZERO; // [R17]
        if (RESET_INSTR_I) begin
          ctl_d[CTL_RUNAWAY_BIT] = 1'b0;
        end else if (CTL_WR_I) begin
          ctl_d = CTL_WDATA_I & CTL_WRITE_MASK;
          if (start_wr && !(bt_run_s_q && bt_osc_s_q)) begin
            // Bad start: reset and flag it, control bits 5..2 kept
            ctl_d                 = (CTL_WDATA_I & CTL_KEEP_ON_WRST);
            ctl_d[CTL_WRST_BIT]   = 1'b1; // [R1] [R14]
            ctl_d[CTL_RUN_BIT]    = 1'b0;
            rst_req_d             = 1'b1; // [R1]
            state_d               = RWDT_RESET;
          end else if (start_wr) begin
            state_d = RWDT_RUN;
          end
        end else if (CTL_BITCLR_I) begin
          // Single-bit clears act as plain writes while stopped
          ctl_d[CTL_BITCLR_IDX_I] = 1'b0;
        end
      end
      RWDT_RUN: begin
        // Register writes ignored here; only the bit-0 clear acts
        if (RESET_INSTR_I) begin
          ctl_d[CTL_RUNAWAY_BIT] = 1'b0;
          ctl_d[CTL_RUN_BIT]     = 1'b0;
          cnt_d                  = WCNT_ZERO;
          state_d                = RWDT_IDLE;
        end else if (HOLD_ENTER_I && ctl_q[CTL_HOLD_BIT]) begin
          ctl_d[CTL_RUN_BIT] = 1'b0; // [R15]
          cnt_d              = WCNT_ZERO;
          state_d            = RWDT_IDLE;
        end else if (clr_hit) begin
          cnt_d = WCNT_ZERO; // [R3] [R4] [R6]
        end else if (overflow) begin
          cnt_d = WCNT_ZERO;
          if (ctl_q[CTL_MODE_BIT]) begin
            ctl_d                  = ctl_q & CTL_KEEP_ON_WRST; // [R8]
            ctl_d[CTL_WRST_BIT]    = 1'b1; // [R14]
            rst_req_d              = 1'b1; // [R5] [R8]
            state_d                = RWDT_RESET;
          end else begin
            ctl_d[CTL_RUNAWAY_BIT] = 1'b1; // [R7] [R16]
            irq_d                  = 1'b1; // [R5] [R8]
          end
        end else if (bt_tick) begin
          cnt_d = cnt_q + 3'h1; // [R13] [R5]
        end
      end
      RWDT_RESET: begin
        // Pulse spent; watchdog stays stopped
        cnt_d   = WCNT_ZERO;
        state_d = RWDT_IDLE;
      end
      default: begin
        state_d = RWDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q   <= RWDT_IDLE;
      ctl_q     <= CTL_RESET_VAL;
      cnt_q     <= WCNT_ZERO;
      rst_req_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      ctl_q     <= ctl_d;
      cnt_q     <= cnt_d;
      rst_req_q <= rst_req_d;
      irq_q     <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  logic [23:0] vec_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      vec_q <= RUNAWAY_VECTOR;
    end else begin
      vec_q <= RUNAWAY_VECTOR; // [R8]
    end
  end

  assign CTL_RDATA_O     = ctl_q;
  assign WDT_COUNT_O     = cnt_q;
  assign WDT_RESET_REQ_O = rst_req_q;
  assign WDT_IRQ_O       = irq_q;
  assign WDT_VECTOR_O    = vec_q;

endmodule // rwdt_top

// *** verif/rwdt_properties.sv ***
`timescale 1ns/1ps
module rwdt_properties
  import rwdt_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic        CTL_WR_I,
  input wire logic [7:0]  CTL_WDATA_I,
  input wire logic        CTL_BITCLR_I,
  input wire logic [2:0]  CTL_BITCLR_IDX_I,
  input wire logic        BT_RUN_I,
  input wire logic        BT_OSC_EN_I,
  input wire logic        HOLD_ENTER_I,
  input wire logic        RESET_INSTR_I,
  input wire logic [7:0]  CTL_RDATA_O,
  input wire logic [2:0]  WDT_COUNT_O,
  input wire logic        WDT_RESET_REQ_O,
  input wire logic        WDT_IRQ_O,
  input wire logic [23:0] WDT_VECTOR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic run;
  logic quiet;
  assign run   = CTL_RDATA_O[CTL_RUN_BIT];
  assign quiet = !RESET_INSTR_I && !HOLD_ENTER_I;
  // Four samples so both pin synchronisers have settled
  sequence s_bt_off; !(BT_RUN_I && BT_OSC_EN_I) [*4]; endsequence
  // Writes in the reset pulse cycle are dropped, so that cycle is left out
  sequence s_start;
    CTL_WR_I && CTL_WDATA_I[0] && !run && quiet && !CTL_BITCLR_I && !WDT_RESET_REQ_O;
  endsequence
  property p_bad_start; s_bt_off ##0 s_start |=> WDT_RESET_REQ_O && !run; endproperty
  a_bad_start: assert property (p_bad_start)
    else $error("start with base timer off gave no reset");
  property p_locked; run |=> $stable({CTL_RDATA_O[5], CTL_RDATA_O[3:2]}); endproperty
  a_locked: assert property (p_locked)
    else $error("control bits changed while running");
  property p_no_stop; run && !CTL_RDATA_O[CTL_MODE_BIT] && quiet |=> run; endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("watchdog stopped unexpectedly");
  property p_clear;
    run && quiet && CTL_BITCLR_I && CTL_BITCLR_IDX_I == 3'h0 |=> WDT_COUNT_O == WCNT_ZERO;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter clear missed");
  property p_idle; !run [*2] |-> WDT_COUNT_O == WCNT_ZERO; endproperty
  a_idle: assert property (p_idle)
    else $error("counter moved while stopped");
  property p_step;
    run |=> WDT_COUNT_O == $past(WDT_COUNT_O) || WDT_COUNT_O == WCNT_ZERO
      || WDT_COUNT_O == $past(WDT_COUNT_O) + 3'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("counter jumped");
  property p_irq;
    WDT_IRQ_O |-> $past(WDT_COUNT_O) == WCNT_LAST && WDT_COUNT_O == WCNT_ZERO
      && CTL_RDATA_O[CTL_RUNAWAY_BIT] && run;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without overflow");
  property p_rst;
    WDT_RESET_REQ_O |-> CTL_RDATA_O[CTL_WRST_BIT] && !run && !CTL_RDATA_O[CTL_RUNAWAY_BIT];
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset request with wrong flags");
  property p_pulse; WDT_RESET_REQ_O || WDT_IRQ_O |=> !WDT_RESET_REQ_O && !WDT_IRQ_O; endproperty
  a_pulse: assert property (p_pulse)
    else $error("request longer than one cycle");
  property p_hold; run && CTL_RDATA_O[CTL_HOLD_BIT] && HOLD_ENTER_I && !RESET_INSTR_I |=> !run;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold did not stop watchdog");
  property p_vec; WDT_VECTOR_O == RUNAWAY_VECTOR; endproperty
  a_vec: assert property (p_vec)
    else $error("wrong vector");
endmodule // rwdt_properties

// *** verif/rwdt_fw_model.sv ***
`timescale 1ns/1ps
module rwdt_fw_model (
  input  wire logic CLK_I,
  input  wire logic run_i,
  input  wire logic kick_i,
  output logic      src_o,
  output logic      clr_o
);
  logic [1:0] ph_q    = 2'h0;
  logic [5:0] edges_q = 6'h00;
  initial clr_o = 1'b0;
  always @(posedge CLK_I) begin
    clr_o <= 1'b0;
    if (run_i) ph_q <= ph_q + 2'h1;
    if (run_i && ph_q == 2'h1) begin
      edges_q <= edges_q + 6'h01;
      // Kick every 64 source edges, well inside the shortest period
      if (edges_q == 6'h3F && kick_i) clr_o <= 1'b1;
    end
  end
  assign src_o = ph_q[1];
endmodule // rwdt_fw_model

// *** verif/test_runaway_watchdog_timer.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_runaway_watchdog_timer;
  import rwdt_pkg::*;
  logic CLK_I = 0, RST_B_I = 0, CTL_WR_I = 0, HOLD_ENTER_I = 0, RESET_INSTR_I = 0;
  logic BT_RUN_I = 0, BT_OSC_EN_I = 0, BT_FAST_I = 0, look = 0, src_on = 0, kick = 0;
  logic [7:0] CTL_WDATA_I = 8'h00, CTL_RDATA_O, rnd = 8'h63, u;
  logic [2:0] CTL_BITCLR_IDX_I = 3'h0, WDT_COUNT_O;
  logic [1:0] BT_COUNT_I = 2'h0;
  logic CTL_BITCLR_I, BT_CLK_EN_I, WDT_RESET_REQ_O, WDT_IRQ_O;
  logic [23:0] WDT_VECTOR_O;
  logic [9:0] notes[$], exp_v;
  int failures = 0, tests_run = 0;
  rwdt_top rwdt_top_i (.*);
  rwdt_fw_model rwdt_fw_model_i (.CLK_I(CLK_I), .run_i(src_on), .kick_i(kick),
    .src_o(BT_CLK_EN_I), .clr_o(CTL_BITCLR_I));
  always #2 CLK_I = ~CLK_I;
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(int n); repeat (n) @(negedge CLK_I); endtask
  task automatic rst(); RST_B_I <= 0; tick(6); RST_B_I <= 1; tick(4); endtask
  task automatic wr(logic [7:0] d);
    @(negedge CLK_I); CTL_WR_I <= 1; CTL_WDATA_I <= d;
    @(negedge CLK_I); CTL_WR_I <= 0;
  endtask
  task automatic chk(logic [9:0] e);
    notes.push_back(e); @(negedge CLK_I); look <= 1; @(negedge CLK_I); look <= 0; tick(1);
  endtask
  task automatic pulse(logic [9:0] e);
    int i;
    notes.push_back(e);
    for (i = 0; i < 1500 && !(WDT_IRQ_O || WDT_RESET_REQ_O); i++) @(negedge CLK_I);
    `CHK("pulse_seen", 1'b1, i < 1500)
    tick(2);
  endtask
  task automatic done(string s); $display("test %s finished", s); endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Unexpected pulses meet an unknown note and so always mismatch
  always @(negedge CLK_I) if (RST_B_I && (look || WDT_IRQ_O || WDT_RESET_REQ_O)) begin
    exp_v = notes.size() > 0 ? notes.pop_front() : 10'bx;
    `CHK("req_ctl", exp_v, {WDT_RESET_REQ_O, WDT_IRQ_O, CTL_RDATA_O})
    `CHK("vector", RUNAWAY_VECTOR, WDT_VECTOR_O)
    // Overflow and bad start both leave the counter at zero
    if (WDT_IRQ_O || WDT_RESET_REQ_O) `CHK("count", WCNT_ZERO, WDT_COUNT_O)
  end
  initial begin
    for (int k = 0; k < 2; k++) begin
      rst(); BT_RUN_I <= k[0]; BT_OSC_EN_I <= ~k[0]; tick(4);
      notes.push_back({2'b10, 8'h30}); wr(8'h21); tick(3);
    end
    done("bad start");
    rst(); BT_RUN_I <= 1; BT_OSC_EN_I <= 1; BT_FAST_I <= 1; rnd = lfsr(rnd);
    BT_COUNT_I <= {1'b0, rnd[0]}; u = {5'h00, rnd[2], 2'b00}; tick(4);
    wr(8'h09 | u); chk({2'b00, 8'h09 | u});
    wr(8'h00); chk({2'b00, 8'h09 | u});
    src_on <= 1; kick <= 1; tick(1500); chk({2'b00, 8'h09 | u});
    kick <= 0; pulse({2'b01, 8'h0B | u}); chk({2'b00, 8'h0B | u});
    @(negedge CLK_I); HOLD_ENTER_I <= 1; @(negedge CLK_I); HOLD_ENTER_I <= 0;
    chk({2'b00, 8'h0A | u});
    done("interrupt mode");
    wr(8'h21); pulse({2'b10, 8'h30});
    done("reset mode");
    rnd = lfsr(rnd); BT_FAST_I <= rnd[3]; BT_COUNT_I <= {1'b1, rnd[4]};
    wr(8'h01); tick(2500); chk({2'b00, 8'h01});
    @(negedge CLK_I); HOLD_ENTER_I <= 1; @(negedge CLK_I); HOLD_ENTER_I <= 0;
    chk({2'b00, 8'h01});
    @(negedge CLK_I); RESET_INSTR_I <= 1; @(negedge CLK_I); RESET_INSTR_I <= 0;
    chk({2'b00, 8'h00});
    done("slow mode");
    give_verdict();
  end
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule // test_runaway_watchdog_timer
bind rwdt_top rwdt_properties rwdt_properties_i (.*);
